// [verilog/smrd_defs.svh]
`ifndef SMRD_DEFS_SVH
`define SMRD_DEFS_SVH

// offsets inside one 4 KiB locality page
`define SMRD_OFF_INT_EN 12'h008
`define SMRD_OFF_CAP 12'h014
`define SMRD_OFF_STS 12'h018
`define SMRD_OFF_MEAS_END 12'h020
`define SMRD_OFF_DATA 12'h024
`define SMRD_OFF_MEAS_START 12'h028
`define SMRD_OFF_IFID 12'h030
`define SMRD_OFF_XDATA 12'h080

// locality pages
`define SMRD_LOC_MAX 4'h4
`define SMRD_NLOC 5

// capability word: max_transfer_size_field position and code
`define SMRD_CAP_XFER_LSB 9
`define SMRD_CAP_XFER_CODE 2'h3
`define SMRD_XFER_MAX_BYTES 16'h0040

// reset and fixed values
`define SMRD_IFID_VALUE 32'h0000_1230
`define SMRD_INT_EN_RESET 32'h0000_0000
`define SMRD_EMPTY_RD 8'hFF
`define SMRD_UNMAPPED_RD 8'h00

`endif

// [verilog/smrd_pkg.sv]
package smrd_pkg;

	typedef enum logic [1:0] {
		BUS_LPC = 2'h0,
		BUS_SPI = 2'h1,
		BUS_I2C = 2'h2
	} smrd_bus_t;

	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_INT_EN = 4'h1,
		SEL_CAP = 4'h2,
		SEL_STS = 4'h3,
		SEL_DATA = 4'h4,
		SEL_IFID = 4'h5,
		SEL_XDATA = 4'h6,
		SEL_MEAS_START = 4'h7,
		SEL_MEAS_END = 4'h8
	} smrd_sel_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_OPEN = 2'b01
	} smrd_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic write;
		smrd_bus_t bus;
	} smrd_txn_t;

	typedef struct packed {
		smrd_sel_t sel;
		logic [1:0] lane;
		logic [2:0] loc;
	} smrd_dec_t;

	typedef struct packed {
		logic [2:0] loc;
		logic ext;
		logic [7:0] data;
	} smrd_push_t;

endpackage : smrd_pkg

// [verilog/smrd_addr_map.sv]
`timescale 1ns/1ps
`include "smrd_defs.svh"

module smrd_addr_map import smrd_pkg::*; (
	// byte address and bus kind
	input wire logic [15:0] addr,
	input wire smrd_bus_t bus,
	// decode result
	output smrd_dec_t dec
);

	wire [3:0] page = addr[15:12];
	wire [11:0] off = addr[11:0];
	wire [11:0] word = {off[11:2], 2'b00};
	wire loc_ok = (page <= `SMRD_LOC_MAX); // [RQ1]
	wire is_l4 = (page == `SMRD_LOC_MAX);
	wire hit_int_en = (word == `SMRD_OFF_INT_EN);
	wire hit_cap = (word == `SMRD_OFF_CAP);
	wire hit_sts = (word == `SMRD_OFF_STS) && (off[1:0] != 2'b11); // [RQ19]
	wire hit_data = (word == `SMRD_OFF_DATA); // [RQ16] [RQ3]
	wire hit_ifid = (word == `SMRD_OFF_IFID); // [RQ11]
	wire hit_xdata = (word == `SMRD_OFF_XDATA) && (bus != BUS_I2C); // [RQ8]
	wire hit_mstart = is_l4 && (off == `SMRD_OFF_MEAS_START); // [RQ4]
	wire hit_mend = is_l4 && (off == `SMRD_OFF_MEAS_END); // [RQ4]
	wire is_port = hit_data || hit_xdata;
	smrd_sel_t sel;

	always_comb begin
		sel = SEL_NONE;
		if (loc_ok) begin
			if (hit_int_en)
				sel = SEL_INT_EN;
			else if (hit_cap)
				sel = SEL_CAP;
			else if (hit_sts)
				sel = SEL_STS;
			else if (hit_data)
				sel = SEL_DATA;
			else if (hit_ifid)
				sel = SEL_IFID;
			else if (hit_xdata)
				sel = SEL_XDATA;
			else if (hit_mstart)
				sel = SEL_MEAS_START;
			else if (hit_mend)
				sel = SEL_MEAS_END;
		end
	end

	// data ports ignore the low address bits, everything else keeps its lane
	assign dec = '{sel: sel, lane: (is_port ? 2'b00 : off[1:0]), loc: page[2:0]};

endmodule : smrd_addr_map

// [verilog/smrd_top.sv]
// Notes on behaviour
// RQ1: locality is address bits 15:12, pages 0 to 4 give localities 0 to 4.
// RQ2: status register is one physical register seen from every locality page.
// RQ3: all addresses of the byte data port alias one internal data path.
// RQ4: measurement command window decodes only in locality 4.
// RQ5: four single-byte writes with rising address build a word, low byte first.
// RQ6: data port bytes need not arrive with addresses stepping modulo four.
// RQ7: one SPI write at extended offset carries many bytes without address advance.
// RQ8: extended data port is not decoded on I2C.
// RQ9: host keeps each access inside one register; device copes if it does not.
// RQ10: single-byte reads and writes inside wider registers are supported.
// RQ11: FIFO identifier register is provided with a fixed value.
// RQ12: oversized SPI read returns start register data, adjacent data real; the code reads adjacent data ports as empty (FF).
// RQ13: oversized SPI write updates start register only; adjacent writes dropped.
// RQ14: a boundary-crossing SPI transaction is never aborted.
// RQ15: transaction state is cleared at each start so nothing leaks forward.
// RQ16: byte data port ignores address bits 1:0; each byte goes to the base.
// RQ17: extended port accepts every length from one byte to the reported maximum.
// RQ18: beyond the maximum, extended bytes pass only while transfer allowance is nonzero.
// RQ19: every other register decodes down to the byte; the code leaves status byte 3 (offset 018 + 3) undecoded.
// RQ20: multi-byte registers are little endian, lowest address holds bits 7:0.
// RQ21: long writes never update a register that starts elsewhere.
// RQ22: long reads return start register data, never abort.
`timescale 1ns/1ps
`include "smrd_defs.svh"

module smrd_top import smrd_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// transaction from host bus front end
	input wire logic txn_start,
	input wire smrd_txn_t txn,
	input wire logic byte_valid,
	input wire logic [7:0] byte_wdata,
	input wire logic txn_end,
	// read answer
	output logic rd_valid,
	output logic [7:0] rd_data,
	// core status
	input wire logic [7:0] sts_flags,
	input wire logic [15:0] sts_allowance,
	// read queue from core, show-ahead
	input wire logic rdq_valid,
	input wire logic [7:0] rdq_data,
	output logic rdq_pop,
	// write data to core
	output logic push_valid,
	output smrd_push_t push,
	// status command byte to core
	output logic sts_cmd_valid,
	output logic [7:0] sts_cmd_data,
	output logic [2:0] sts_cmd_loc,
	// measurement window pulses
	output logic meas_start,
	output logic meas_end,
	output logic [7:0] meas_data,
	// configuration and state
	output logic [`SMRD_NLOC-1:0][31:0] int_enable,
	output logic [2:0] active_loc,
	output logic txn_open,
	output logic cross_seen,
	output logic drop_seen
);

	localparam logic [31:0] CAP_WORD =
		{30'h0000_0000, `SMRD_CAP_XFER_CODE} << `SMRD_CAP_XFER_LSB;

	// byte select from a little-endian word
	function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] lane);
		lane_byte = w[{lane, 3'b000} +: 8]; // [RQ20]
	endfunction : lane_byte

	// true for the two streaming data ports
	function automatic logic is_port(input smrd_sel_t s);
		is_port = (s == SEL_DATA) || (s == SEL_XDATA);
	endfunction : is_port

	// one little-endian byte lane replaced inside a word
	function automatic logic [31:0] lane_merge(input logic [31:0] w, input logic [1:0] lane,
		input logic [7:0] b);
		logic [31:0] r;
		r = w;
		r[{lane, 3'b000} +: 8] = b;
		lane_merge = r;
	endfunction : lane_merge

	smrd_state_t state_reg;
	smrd_state_t state_next;
	smrd_txn_t txn_reg;
	logic [15:0] addr_reg;
	logic [15:0] addr_next;
	logic first_reg;
	smrd_dec_t start_dec_reg;
	logic [15:0] count_reg;
	logic [`SMRD_NLOC-1:0][31:0] int_en_reg;
	logic rd_valid_reg;
	logic [7:0] rd_data_reg;
	logic rdq_pop_reg;
	logic push_valid_reg;
	smrd_push_t push_reg;
	logic sts_cmd_valid_reg;
	logic [7:0] sts_cmd_data_reg;
	logic [2:0] sts_cmd_loc_reg;
	logic meas_start_reg;
	logic meas_end_reg;
	logic [7:0] meas_data_reg;
	logic [2:0] active_loc_reg;
	logic cross_seen_reg;
	logic drop_seen_reg;
	logic txn_open_reg;
	wire [`SMRD_NLOC-1:0][31:0] int_en_next;
	smrd_dec_t cur_dec;

	// decode of the byte currently addressed
	smrd_addr_map u_map (
		.addr(addr_reg),
		.bus(txn_reg.bus),
		.dec(cur_dec)
	);

	wire open_st = (state_reg == ST_OPEN);
	// a byte beside a new start belongs to no transaction and is ignored
	wire byte_go = open_st && byte_valid && !txn_start; // [RQ15]
	wire wr_byte = byte_go && txn_reg.write;
	wire rd_byte = byte_go && !txn_reg.write;
	// the first byte compares against itself, so it never counts as a crossing
	wire smrd_dec_t start_dec = first_reg ? cur_dec : start_dec_reg;
	// any change of register or locality after the first byte is a crossing
	wire crossing = (cur_dec.sel != start_dec.sel) || (cur_dec.loc != start_dec.loc);
	wire mapped = (cur_dec.sel != SEL_NONE);
	// the limit counts every extended byte of the transaction, kept or dropped
	wire over_max = (count_reg >= `SMRD_XFER_MAX_BYTES); // [RQ17]
	wire xd_allowed = !over_max || (sts_allowance != 16'h0000); // [RQ18]
	wire port_ok = (cur_dec.sel != SEL_XDATA) || xd_allowed;
	// writes outside the start register are dropped, state untouched
	wire wr_ok = wr_byte && mapped && !crossing && port_ok; // [RQ13] [RQ21]
	wire wr_drop = wr_byte && !wr_ok;
	wire rd_port = rd_byte && is_port(cur_dec.sel) && !crossing && port_ok;
	// a pop still in flight means the shown head is already taken; reading it
	// again would hand one queue byte out twice, so that byte reads as empty
	wire head_ok = rdq_valid && !rdq_pop_reg; // [RQ16]
	wire pop_ok = rd_port && head_ok;
	wire loc_in = (cur_dec.loc <= 3'(`SMRD_LOC_MAX));
	wire [31:0] int_en_cur = loc_in ? int_en_reg[cur_dec.loc] : 32'h0000_0000;
	wire [31:0] sts_word = {8'h00, sts_allowance, sts_flags}; // [RQ2]
	wire [7:0] port_byte = head_ok ? rdq_data : `SMRD_EMPTY_RD;
	logic [7:0] rd_mux;

	// read selection; adjacent registers of an oversized read give real data, adjacent data ports read as empty
	always_comb begin
		rd_mux = `SMRD_UNMAPPED_RD;
		unique case (cur_dec.sel)
			SEL_INT_EN: rd_mux = lane_byte(int_en_cur, cur_dec.lane); // [RQ10] [RQ12]
			SEL_CAP: rd_mux = lane_byte(CAP_WORD, cur_dec.lane);
			SEL_STS: rd_mux = lane_byte(sts_word, cur_dec.lane); // [RQ2]
			SEL_IFID: rd_mux = lane_byte(`SMRD_IFID_VALUE, cur_dec.lane); // [RQ11]
			SEL_DATA: rd_mux = rd_port ? port_byte : `SMRD_EMPTY_RD; // [RQ3]
			SEL_XDATA: rd_mux = rd_port ? port_byte : `SMRD_EMPTY_RD; // [RQ7]
			SEL_MEAS_START: rd_mux = `SMRD_UNMAPPED_RD;
			SEL_MEAS_END: rd_mux = `SMRD_UNMAPPED_RD;
			SEL_NONE: rd_mux = `SMRD_UNMAPPED_RD;
			default: rd_mux = `SMRD_UNMAPPED_RD;
		endcase
	end

	// transaction sequencing; a new start always wins and clears everything
	always_comb begin
		state_next = state_reg;
		if (txn_start)
			state_next = ST_OPEN; // [RQ15]
		else if (txn_end)
			state_next = ST_IDLE;
	end

	// the ports hold their address, other registers step one byte each
	always_comb begin
		addr_next = addr_reg;
		if (txn_start)
			addr_next = txn.addr;
		else if (byte_go && !is_port(cur_dec.sel))
			addr_next = addr_reg + 16'h0001; // [RQ5]
	end

	// open flag kept beside the state so the output comes from a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			txn_open_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			txn_open_reg <= (state_next == ST_OPEN);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txn_reg <= '{addr: 16'h0000, write: 1'b0, bus: BUS_LPC};
			active_loc_reg <= 3'h0;
		end else if (txn_start) begin
			txn_reg <= txn;
			active_loc_reg <= txn.addr[14:12]; // [RQ1]
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			addr_reg <= 16'h0000;
		else
			addr_reg <= addr_next;
	end

	// start register of the transaction, caught at its first byte
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			first_reg <= 1'b1;
			start_dec_reg <= '{sel: SEL_NONE, lane: 2'b00, loc: 3'h0};
		end else if (txn_start) begin
			first_reg <= 1'b1; // [RQ15]
		end else if (byte_go && first_reg) begin
			first_reg <= 1'b0;
			start_dec_reg <= cur_dec;
		end
	end

	// extended port byte count for the length limit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			count_reg <= 16'h0000;
		else if (txn_start)
			count_reg <= 16'h0000; // [RQ15]
		else if (byte_go && (cur_dec.sel == SEL_XDATA) && (count_reg != 16'hFFFF))
			count_reg <= count_reg + 16'h0001;
	end

	// crossing and drop flags per transaction; a crossing never aborts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cross_seen_reg <= 1'b0;
			drop_seen_reg <= 1'b0;
		end else if (txn_start) begin
			cross_seen_reg <= 1'b0;
			drop_seen_reg <= 1'b0;
		end else if (byte_go) begin
			cross_seen_reg <= cross_seen_reg || crossing; // [RQ14]
			drop_seen_reg <= drop_seen_reg || wr_drop;
		end
	end

	// per-locality interrupt enable copies, byte-wide writes
	generate
		for (genvar g = 0; g < `SMRD_NLOC; g++) begin : g_loc
			wire hit = wr_ok && (cur_dec.sel == SEL_INT_EN) && (cur_dec.loc == 3'(g));
			wire [31:0] merged = lane_merge(int_en_reg[g], cur_dec.lane, byte_wdata);
			assign int_en_next[g] = hit ? merged : int_en_reg[g]; // [RQ10] [RQ20]
		end
	endgenerate

	// the whole bank is written by one process
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			int_en_reg <= {`SMRD_NLOC{`SMRD_INT_EN_RESET}};
		else
			int_en_reg <= int_en_next;
	end

	// read answer one cycle after the byte request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			rd_valid_reg <= rd_byte; // [RQ22]
			if (rd_byte)
				rd_data_reg <= rd_mux;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rdq_pop_reg <= 1'b0;
		else
			rdq_pop_reg <= pop_ok; // [RQ6]
	end

	// data bytes to the core, one per accepted write at either port
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			push_valid_reg <= 1'b0;
			push_reg <= '{loc: 3'h0, ext: 1'b0, data: 8'h00};
		end else begin
			push_valid_reg <= wr_ok && is_port(cur_dec.sel); // [RQ16] [RQ7]
			if (wr_ok && is_port(cur_dec.sel))
				push_reg <= '{loc: cur_dec.loc, ext: (cur_dec.sel == SEL_XDATA),
					data: byte_wdata};
		end
	end

	// status byte 0 is a command; upper bytes are read only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sts_cmd_valid_reg <= 1'b0;
			sts_cmd_data_reg <= 8'h00;
			sts_cmd_loc_reg <= 3'h0;
		end else begin
			sts_cmd_valid_reg <= wr_ok && (cur_dec.sel == SEL_STS) && (cur_dec.lane == 2'b00);
			if (wr_ok && (cur_dec.sel == SEL_STS) && (cur_dec.lane == 2'b00)) begin
				sts_cmd_data_reg <= byte_wdata; // [RQ2]
				sts_cmd_loc_reg <= cur_dec.loc;
			end
		end
	end

	// measurement window strobes, locality 4 only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meas_start_reg <= 1'b0;
			meas_end_reg <= 1'b0;
			meas_data_reg <= 8'h00;
		end else begin
			meas_start_reg <= wr_ok && (cur_dec.sel == SEL_MEAS_START); // [RQ4]
			meas_end_reg <= wr_ok && (cur_dec.sel == SEL_MEAS_END); // [RQ4]
			if (wr_ok && ((cur_dec.sel == SEL_MEAS_START) || (cur_dec.sel == SEL_MEAS_END)))
				meas_data_reg <= byte_wdata;
		end
	end

	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign rdq_pop = rdq_pop_reg;
	assign push_valid = push_valid_reg;
	assign push = push_reg;
	assign sts_cmd_valid = sts_cmd_valid_reg;
	assign sts_cmd_data = sts_cmd_data_reg;
	assign sts_cmd_loc = sts_cmd_loc_reg;
	assign meas_start = meas_start_reg;
	assign meas_end = meas_end_reg;
	assign meas_data = meas_data_reg;
	assign int_enable = int_en_reg;
	assign active_loc = active_loc_reg;
	assign txn_open = txn_open_reg;
	assign cross_seen = cross_seen_reg;
	assign drop_seen = drop_seen_reg;

endmodule : smrd_top

// [tb/smrd_checker.sv]
`timescale 1ns/1ps
`include "smrd_defs.svh"

module smrd_checker import smrd_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// host side and core read queue
	input wire logic txn_start,
	input wire smrd_txn_t txn,
	input wire logic byte_valid,
	input wire logic [7:0] byte_wdata,
	input wire logic txn_end,
	input wire logic rdq_valid,
	input wire logic [7:0] rdq_data,
	// design outputs
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic rdq_pop,
	input wire logic push_valid,
	input wire smrd_push_t push,
	input wire logic sts_cmd_valid,
	input wire logic [7:0] sts_cmd_data,
	input wire logic [2:0] sts_cmd_loc,
	input wire logic meas_start,
	input wire logic [`SMRD_NLOC-1:0][31:0] int_enable,
	input wire logic [2:0] active_loc,
	input wire logic txn_open
);
	logic wr_reg;
	logic wr_next;
	logic rd_take;
	logic wr_take;
	// direction of the open transaction
	assign wr_next = txn_start ? txn.write : wr_reg;
	assign rd_take = byte_valid && txn_open && !txn_start && !txn_end && !wr_reg;
	assign wr_take = byte_valid && wr_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			wr_reg <= 1'h0;
		else
			wr_reg <= wr_next;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_read_answer_due: assert property (rd_take |=> rd_valid)
		else $error("read byte got no answer");
	a_rd_from_read: assert property (rd_valid |-> $past(byte_valid && !wr_reg))
		else $error("read answer without read byte");
	a_push_from_write: assert property (push_valid |->
		$past(wr_take) && push.data == $past(byte_wdata))
		else $error("push without matching write byte");
	a_pop_with_read: assert property (rdq_pop |->
		rd_valid && $past(rdq_valid) && rd_data == $past(rdq_data))
		else $error("pop does not match read data");
	a_pop_spaced: assert property (rdq_pop |=> !rdq_pop)
		else $error("queue popped on two cycles in a row");
	a_open_loc_set: assert property (txn_start |=>
		txn_open && active_loc == $past(txn.addr[14:12]))
		else $error("start did not open with its locality");
	a_close_on_end: assert property (txn_end && !txn_start |=> !txn_open)
		else $error("end did not close transaction");
	a_meas_page_four: assert property (meas_start |-> active_loc == 3'h4)
		else $error("measurement pulse outside page four");
	a_sts_cmd_src: assert property (sts_cmd_valid |-> $past(wr_take) &&
		sts_cmd_data == $past(byte_wdata) && sts_cmd_loc == active_loc)
		else $error("status command not from write byte");
	a_push_loc_match: assert property (push_valid |-> push.loc == active_loc)
		else $error("push locality wrong");
	a_ie_write_only: assert property (!$stable(int_enable) |-> $past(wr_take))
		else $error("enable register changed without write");
	c_read: cover property (rd_valid && rdq_pop);
	c_ext_push: cover property (push_valid && push.ext);
	c_meas: cover property (meas_start);
endmodule : smrd_checker

bind smrd_top smrd_checker u_chk (.clk, .nrst, .txn_start, .txn, .byte_valid, .byte_wdata,
	.txn_end, .rdq_valid, .rdq_data, .rd_valid, .rd_data, .rdq_pop, .push_valid, .push,
	.sts_cmd_valid, .sts_cmd_data, .sts_cmd_loc, .meas_start, .int_enable, .active_loc,
	.txn_open);

// [tb/smrd_core_model.sv]
`timescale 1ns/1ps

module smrd_core_model #(
	parameter int DEPTH = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// read queue
	input wire logic stall,
	input wire logic rdq_pop,
	output logic rdq_valid,
	output logic [7:0] rdq_data
);
	int idx;
	// an empty or stalled queue shows the inverted index, never the last byte
	assign rdq_valid = !stall && idx < DEPTH;
	assign rdq_data = rdq_valid ? 8'hA0 + idx[7:0] : ~idx[7:0];
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			idx <= 0;
		else if (rdq_pop)
			idx <= idx + 1;
	end
endmodule : smrd_core_model

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "smrd_defs.svh"

module testbench import smrd_pkg::*;;
	logic clk, nrst, txn_start, byte_valid, txn_end, stall, rd_valid, rdq_valid, rdq_pop;
	logic push_valid, sts_cmd_valid, meas_start, meas_end, txn_open, cross_seen, drop_seen;
	logic [7:0] byte_wdata, sts_flags, rd_data, rdq_data, sts_cmd_data, meas_data;
	logic [15:0] sts_allowance;
	logic [2:0] sts_cmd_loc, active_loc;
	logic [`SMRD_NLOC-1:0][31:0] int_enable;
	smrd_txn_t txn;
	smrd_push_t push;
	int mismatches, num_checks, nmeas, nmend, nsts;
	logic [7:0] wq[$], got_rd[$], exp_rd[$];
	smrd_push_t got_push[$];
	logic [31:0] ie[5];

	smrd_top DUT (.clk, .nrst, .txn_start, .txn, .byte_valid, .byte_wdata, .txn_end, .rd_valid,
		.rd_data, .sts_flags, .sts_allowance, .rdq_valid, .rdq_data, .rdq_pop, .push_valid,
		.push, .sts_cmd_valid, .sts_cmd_data, .sts_cmd_loc, .meas_start, .meas_end, .meas_data,
		.int_enable, .active_loc, .txn_open, .cross_seen, .drop_seen);
	smrd_core_model #(.DEPTH(3)) u_core (.clk, .nrst, .stall, .rdq_pop, .rdq_valid, .rdq_data);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	always @(negedge clk) begin
		if (rd_valid) got_rd.push_back(rd_data);
		if (push_valid) got_push.push_back(push);
		if (meas_start) nmeas++;
		if (meas_end) nmend++;
		if (sts_cmd_valid) nsts++;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	task automatic fill(input int n);
		wq.delete();
		repeat (n) wq.push_back(8'($urandom()));
	endtask : fill

	task automatic expw(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++) exp_rd.push_back(v[8*i+:8]);
	endtask : expw

	// one host transaction, bytes back to back
	task automatic xfer(input logic [15:0] a, input logic w, input smrd_bus_t b, input int n);
		got_rd.delete();
		got_push.delete();
		nmeas = 0;
		nmend = 0;
		nsts = 0;
		txn_start = 1'h1;
		txn = '{a, w, b};
		@(negedge clk);
		txn_start = 1'h0;
		for (int i = 0; i < n; i++) begin
			byte_valid = 1'h1;
			byte_wdata = w ? wq[i] : 8'h00;
			@(negedge clk);
		end
		byte_valid = 1'h0;
		txn_end = 1'h1;
		@(negedge clk);
		txn_end = 1'h0;
		@(negedge clk);
	endtask : xfer

	task automatic cmp_rd();
		chk(got_rd.size(), exp_rd.size());
		foreach (exp_rd[i]) if (i < got_rd.size()) chk(got_rd[i], exp_rd[i]);
		exp_rd.delete();
	endtask : cmp_rd

	task automatic cmp_push(input logic [2:0] loc, input logic ext, input int n);
		chk(got_push.size(), n);
		for (int i = 0; i < n && i < got_push.size(); i++) chk(got_push[i], {loc, ext, wq[i]});
	endtask : cmp_push

	initial begin
		#500us;
		mismatches++;
		test_done();
	end

	initial begin
		nrst = 1'h0;
		{txn_start, byte_valid, txn_end, stall, byte_wdata, sts_flags, sts_allowance} = '0;
		txn = '0;
		void'($urandom(25));
		repeat (16) @(negedge clk);
		nrst = 1'h1;
		@(negedge clk);
		for (int l = 0; l < 5; l++) begin
			chk(int_enable[l], 32'h0);
			fill(4);
			xfer({l[3:0], 12'h008}, 1'h1, smrd_bus_t'(l % 3), 4);
			ie[l] = {wq[3], wq[2], wq[1], wq[0]};
			chk(int_enable[l], ie[l]);
		end
		fill(1);
		xfer(16'h100A, 1'h1, BUS_SPI, 1);
		ie[1][23:16] = wq[0];
		chk(int_enable[1], ie[1]);
		sts_flags = 8'($urandom());
		sts_allowance = 16'($urandom());
		for (int l = 0; l < 5; l++) begin
			xfer({l[3:0], 12'h008}, 1'h0, BUS_LPC, 4);
			expw(ie[l], 4);
			cmp_rd();
			xfer({l[3:0], 12'h018}, 1'h0, BUS_SPI, 4);
			expw({8'h00, sts_allowance, sts_flags}, 4);
			cmp_rd();
		end
		xfer(16'h5018, 1'h0, BUS_LPC, 1);
		expw(32'h0, 1);
		cmp_rd();
		xfer(16'h0030, 1'h0, BUS_LPC, 4);
		expw(`SMRD_IFID_VALUE, 4);
		cmp_rd();
		fill(1);
		xfer(16'h3018, 1'h1, BUS_LPC, 1);
		chk(nsts, 1);
		fill(4);
		xfer(16'h0025, 1'h1, BUS_SPI, 4);
		cmp_push(3'h0, 1'h0, 4);
		stall = 1'h1;
		xfer(16'h2026, 1'h0, BUS_LPC, 1);
		stall = 1'h0;
		expw(32'hFF, 1);
		cmp_rd();
		xfer(16'h0024, 1'h0, BUS_SPI, 4);
		expw(32'hFFA1FFA0, 4);
		cmp_rd();
		fill(1);
		xfer(16'h4028, 1'h1, BUS_LPC, 1);
		chk(nmeas, 1);
		chk(meas_data, wq[0]);
		xfer(16'h0028, 1'h1, BUS_LPC, 1);
		chk({nmeas[0], drop_seen}, 2'h1);
		fill(1);
		xfer(16'h4020, 1'h1, BUS_LPC, 1);
		chk({nmend[0], nmeas[0], meas_data}, {2'h2, wq[0]});
		fill(65);
		sts_allowance = 16'h0000;
		xfer(16'h1080, 1'h1, BUS_SPI, 64);
		cmp_push(3'h1, 1'h1, 64);
		xfer(16'h1080, 1'h1, BUS_SPI, 65);
		cmp_push(3'h1, 1'h1, 64);
		sts_allowance = 16'h0001;
		xfer(16'h1080, 1'h1, BUS_SPI, 65);
		cmp_push(3'h1, 1'h1, 65);
		xfer(16'h0080, 1'h1, BUS_I2C, 2);
		chk(got_push.size(), 0);
		fill(8);
		xfer(16'h2004, 1'h1, BUS_SPI, 8);
		chk(int_enable[2], ie[2]);
		chk({cross_seen, txn_open}, 2'h2);
		xfer(16'h0014, 1'h0, BUS_SPI, 8);
		expw(32'(`SMRD_CAP_XFER_CODE) << `SMRD_CAP_XFER_LSB, 4);
		expw({8'h00, sts_allowance, sts_flags}, 4);
		cmp_rd();
		fill(1);
		xfer(16'h2009, 1'h1, BUS_LPC, 1);
		ie[2][15:8] = wq[0];
		chk(cross_seen, 1'h0);
		chk(int_enable[2], ie[2]);
		test_done();
	end
endmodule : testbench
